// ===== design/tpcds_regs.vh
// register offsets, field positions and reset values of the touch preprocessor bank
// assumes word-wide registers on a 32-bit bus; byte address is four times the index
`ifndef TPCDS_REGS_VH
`define TPCDS_REGS_VH

// register indices
`define TPCDS_IDX_PRECFG 6'h0e
`define TPCDS_IDX_CFNSTAT 6'h0f
`define TPCDS_IDX_DEVSTAT 6'h10
`define TPCDS_IDX_IRQSTAT 6'h11
`define TPCDS_IDX_IRQMASK 6'h12

// preprocessor_config fields
`define TPCDS_CFG_FMT 15
`define TPCDS_CFG_SRC 14
`define TPCDS_CFG_M_HI 13
`define TPCDS_CFG_M_LO 12
`define TPCDS_CFG_W_HI 11
`define TPCDS_CFG_W_LO 10
`define TPCDS_CFG_FILTER_ENABLE_PER_MEASURE_HI 4
`define TPCDS_CFG_FILTER_ENABLE_PER_MEASURE_LO 1
`define TPCDS_CFG_RESET 16'h0000

// converter_function_status fields
`define TPCDS_CFN_DRV_HI 15
`define TPCDS_CFN_DRV_LO 13
`define TPCDS_CFN_RUN_HI 8
`define TPCDS_CFN_RUN_LO 0
`define TPCDS_CFN_RESET 16'h0000
`define TPCDS_RUN_COUNT 4'h9

// device status fields
`define TPCDS_DEV_DAV_HI 4
`define TPCDS_DEV_DAV_LO 0
`define TPCDS_DEV_BUSY 5
`define TPCDS_DEV_PEN 6

// interrupt status and mask fields
`define TPCDS_IRQ_DAV 0
`define TPCDS_IRQ_DONE 1
`define TPCDS_IRQ_PEN 2
`define TPCDS_IRQ_WIDTH 3
`define TPCDS_IRQ_RESET 3'h0

// ahb encodings
`define TPCDS_HTRANS_NONSEQ 2'h2
`define TPCDS_HTRANS_SEQ 2'h3
`define TPCDS_HSIZE_WORD 3'h2

`endif

// ===== design/tpcds_core.v
// touch preprocessor config, converter function status and driver status bank
// assumes an ahb-lite master on clk and converter control logic on the same clock
//
// Contract
// - format bit 0 puts pen-touch and data-available AND onto shared pin, 1 pen only
// - source bit 1 puts data-available on shared pin, else format bit decides
// - pen touch and data available both appear active low on shared pin
// - converter busy and matching data-available stay busy until filtering completes
// - all-zero filter parameter fields bypass the preprocessor, raw results pass
// - both two-bit filter fields read back as written, reset to 00
// - four-bit per-measurement filter enable, reset zero, applies filter per type
// - horizontal driver bit reads 1 while both x plate drivers are on
// - vertical driver bit reads 1 while both y plate drivers are on
// - top driver bit reads 1 while y positive and x negative drivers are on
// - driver bits clear on function done, stop, pin reset or software reset
// - function status register at index f, resets zero, read only, reserved zero
// - running flag x set while function code x runs, cleared on done, stop, reset
// - data-available bit sets on store of its type, holds until host reads it
//
// Implementation choice: the AHB-Lite register port.
`include "tpcds_regs.vh"
`default_nettype none

module tpcds_core #(
    parameter DAV_COUNT = 5
) (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire swReset,
    input wire convStop,
    input wire funcStart,
    input wire [3:0] funcCode,
    input wire funcDone,
    input wire drvXPos,
    input wire drvXNeg,
    input wire drvYPos,
    input wire drvYNeg,
    input wire penTouch,
    input wire filterBusy,
    input wire dataStore,
    input wire [2:0] dataStoreType,
    input wire dataRead,
    input wire [2:0] dataReadType,
    output reg sharedTouchDataPin,
    output reg convBusy,
    output reg preprocBypass,
    output reg [3:0] filterApply,
    output reg irq
);

    localparam ST_IDLE = 2'b01;
    localparam ST_DATA = 2'b10;

    reg [1:0] busState;
    reg [5:0] dataIdx;
    reg dataWrite;

    reg pinFormatSelect;
    reg pinSourceSelect;
    reg [1:0] filterM;
    reg [1:0] filterW;
    reg [3:0] filterEnablePerMeasure;

    reg [2:0] driverOnStatus;
    reg [8:0] runningFunctionFlags;
    reg [DAV_COUNT-1:0] dataAvailableFlag;
    reg [DAV_COUNT-1:0] davPending;
    reg [`TPCDS_IRQ_WIDTH-1:0] irqStatus;
    reg [`TPCDS_IRQ_WIDTH-1:0] irqMask;
    reg penPrev;

    wire anyReset;
    wire takeReq;
    wire stopNow;
    wire filterOn;
    wire penIrqN;
    wire davN;
    wire [DAV_COUNT-1:0] storeMask;
    wire [DAV_COUNT-1:0] readMask;
    wire [DAV_COUNT-1:0] davRise;
    wire [`TPCDS_IRQ_WIDTH-1:0] irqEvents;
    wire [`TPCDS_IRQ_WIDTH-1:0] irqClear;
    wire [15:0] cfgWord;
    wire [15:0] cfnWord;
    wire [15:0] devWord;
    wire [5:0] addrIdx;

    reg [8:0] next_running;
    reg [2:0] next_driver;
    reg [DAV_COUNT-1:0] next_dav;
    reg [DAV_COUNT-1:0] next_pending;
    reg next_pin;
    reg [31:0] next_rdata;

    // one-hot mask of a measurement type
    function [DAV_COUNT-1:0] typeMask;
        input [2:0] t;
        integer i;
        begin
            typeMask = {DAV_COUNT{1'b0}};
            for (i = 0; i < DAV_COUNT; i = i + 1) begin
                if (t == i[2:0]) begin
                    typeMask[i] = 1'b1;
                end
            end
        end
    endfunction

    assign anyReset = rst | swReset;
    assign stopNow = funcDone | convStop;
    assign takeReq = hsel & hready & htrans[1];
    assign addrIdx = haddr[7:2];
    assign filterOn = (filterM != 2'h0) | (filterW != 2'h0);
    assign storeMask = dataStore ? typeMask(dataStoreType) : {DAV_COUNT{1'b0}};
    assign readMask = dataRead ? typeMask(dataReadType) : {DAV_COUNT{1'b0}};
    assign davRise = next_dav & ~dataAvailableFlag;
    assign penIrqN = ~penTouch;
    assign davN = ~(|dataAvailableFlag);

    assign cfgWord = {pinFormatSelect, pinSourceSelect, filterM, filterW, 5'h00,
                      filterEnablePerMeasure, 1'b0};
    assign cfnWord = {driverOnStatus, 4'h0, runningFunctionFlags};
    assign devWord = {9'h000, penTouch, convBusy, dataAvailableFlag[4:0]};

    assign irqEvents = {penTouch & ~penPrev, funcDone, |davRise};
    assign irqClear = (dataWrite && dataIdx == `TPCDS_IDX_IRQSTAT) ?
                      hwdata[`TPCDS_IRQ_WIDTH-1:0] : {`TPCDS_IRQ_WIDTH{1'b0}};

    // running function flags
    always @* begin
        next_running = runningFunctionFlags;
        if (stopNow) begin
            next_running = 9'h000;
        end else if (funcStart) begin
            next_running = 9'h000;
            if (funcCode < `TPCDS_RUN_COUNT) begin
                next_running[funcCode] = 1'b1;
            end
        end
    end

    // driver status from plate drivers
    always @* begin
        next_driver = 3'h0;
        if (!stopNow) begin
            next_driver[0] = drvXPos & drvXNeg;
            next_driver[1] = drvYPos & drvYNeg;
            next_driver[2] = drvYPos & drvXNeg;
        end
    end

    // data available set, held while filtering, cleared by host read
    always @* begin
        next_pending = davPending;
        next_dav = dataAvailableFlag & ~readMask;
        if (filterOn && filterBusy) begin
            next_pending = davPending | storeMask;
        end else begin
            next_dav = next_dav | storeMask | davPending;
            next_pending = {DAV_COUNT{1'b0}};
        end
    end

    // shared pin selection
    always @* begin
        if (pinSourceSelect) begin
            next_pin = davN;
        end else if (pinFormatSelect) begin
            next_pin = penIrqN;
        end else begin
            next_pin = penIrqN & davN;
        end
    end

    // read data mux
    always @* begin
        next_rdata = 32'h00000000;
        case (addrIdx)
            `TPCDS_IDX_PRECFG: begin
                next_rdata = {16'h0000, cfgWord};
            end
            `TPCDS_IDX_CFNSTAT: begin
                next_rdata = {16'h0000, cfnWord};
            end
            `TPCDS_IDX_DEVSTAT: begin
                next_rdata = {16'h0000, devWord};
            end
            `TPCDS_IDX_IRQSTAT: begin
                next_rdata = {29'h00000000, irqStatus};
            end
            `TPCDS_IDX_IRQMASK: begin
                next_rdata = {29'h00000000, irqMask};
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // ahb-lite slave, zero wait states
    always @(posedge clk) begin
        if (rst) begin
            busState <= ST_IDLE;
            dataIdx <= 6'h00;
            dataWrite <= 1'b0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            case (busState)
                ST_IDLE: begin
                    dataWrite <= takeReq & hwrite;
                    dataIdx <= addrIdx;
                    if (takeReq) begin
                        busState <= ST_DATA;
                        if (!hwrite) begin
                            hrdata <= next_rdata;
                        end
                    end
                end
                ST_DATA: begin
                    dataWrite <= takeReq & hwrite;
                    dataIdx <= addrIdx;
                    if (takeReq) begin
                        if (!hwrite) begin
                            hrdata <= next_rdata;
                        end
                    end else begin
                        busState <= ST_IDLE;
                    end
                end
                default: begin
                    busState <= ST_IDLE;
                    dataWrite <= 1'b0;
                end
            endcase
        end
    end

    // configuration and interrupt mask registers
    always @(posedge clk) begin
        if (anyReset) begin
            pinFormatSelect <= 1'b0;
            pinSourceSelect <= 1'b0;
            filterM <= 2'h0;
            filterW <= 2'h0;
            filterEnablePerMeasure <= 4'h0;
            irqMask <= `TPCDS_IRQ_RESET;
        end else if (dataWrite) begin
            if (dataIdx == `TPCDS_IDX_PRECFG) begin
                pinFormatSelect <= hwdata[`TPCDS_CFG_FMT];
                pinSourceSelect <= hwdata[`TPCDS_CFG_SRC];
                filterM <= hwdata[`TPCDS_CFG_M_HI:`TPCDS_CFG_M_LO];
                filterW <= hwdata[`TPCDS_CFG_W_HI:`TPCDS_CFG_W_LO];
                filterEnablePerMeasure <= hwdata[`TPCDS_CFG_FILTER_ENABLE_PER_MEASURE_HI:`TPCDS_CFG_FILTER_ENABLE_PER_MEASURE_LO];
            end
            if (dataIdx == `TPCDS_IDX_IRQMASK) begin
                irqMask <= hwdata[`TPCDS_IRQ_WIDTH-1:0];
            end
        end
    end

    // converter status and outputs
    always @(posedge clk) begin
        if (anyReset) begin
            runningFunctionFlags <= 9'h000;
            driverOnStatus <= 3'h0;
            dataAvailableFlag <= {DAV_COUNT{1'b0}};
            davPending <= {DAV_COUNT{1'b0}};
            irqStatus <= `TPCDS_IRQ_RESET;
            penPrev <= 1'b0;
            sharedTouchDataPin <= 1'b1;
            convBusy <= 1'b0;
            preprocBypass <= 1'b1;
            filterApply <= 4'h0;
            irq <= 1'b0;
        end else begin
            runningFunctionFlags <= next_running;
            driverOnStatus <= next_driver;
            dataAvailableFlag <= next_dav;
            davPending <= next_pending;
            irqStatus <= (irqStatus & ~irqClear) | irqEvents;
            penPrev <= penTouch;
            sharedTouchDataPin <= next_pin;
            convBusy <= (|next_running) | (filterOn & filterBusy);
            preprocBypass <= ~filterOn;
            filterApply <= filterOn ? filterEnablePerMeasure : 4'h0;
            irq <= |(((irqStatus & ~irqClear) | irqEvents) & irqMask);
        end
    end

endmodule

`default_nettype wire

// ===== sim/tpcds_core_props.sv
// assertions on the touch preprocessor bank ports
// assumes a bind into tpcds_core, one clock, sync reset
`default_nettype none
module tpcds_core_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic swReset,
    input wire logic convStop,
    input wire logic funcStart,
    input wire logic [3:0] funcCode,
    input wire logic funcDone,
    input wire logic filterBusy,
    input wire logic convBusy,
    input wire logic preprocBypass,
    input wire logic [3:0] filterApply,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_bypass_gates: assert property (preprocBypass |-> filterApply == 4'h0)
        else $error("apply while bypassed");
    chk_start_busy: assert property (funcStart && funcCode < 4'h9 && !funcDone
        && !convStop && !swReset |=> convBusy) else $error("start not busy");
    chk_bad_code: assert property (funcStart && funcCode > 4'h8 && !convBusy
        && !filterBusy |=> !convBusy) else $error("bad code ran");
    chk_done_idle: assert property (funcDone && !filterBusy |=> !convBusy)
        else $error("busy after done");
    chk_stop_idle: assert property (convStop && !filterBusy |=> !convBusy)
        else $error("busy after stop");
    chk_filter_busy: assert property (filterBusy && !preprocBypass && !swReset
        |=> convBusy) else $error("filter not busy");
    chk_busy_cause: assert property ($rose(convBusy) |->
        $past(funcStart) || $past(filterBusy)) else $error("busy without cause");
    chk_soft_reset: assert property (swReset |=> !convBusy && !irq
        && preprocBypass && filterApply == 4'h0) else $error("soft reset missed");
    cover property (funcStart ##1 convBusy);
    cover property (filterBusy && !preprocBypass);
    cover property ($fell(irq));
endmodule
bind tpcds_core tpcds_core_props i_props (.*);
`default_nettype wire

// ===== sim/tpcds_host.sv
// ahb-lite master model standing for the host processor
// assumes one slave whose hreadyout is fed back as hready
`default_nettype none
module tpcds_host (
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output var logic hsel,
    output var logic [31:0] haddr,
    output var logic [1:0] htrans,
    output var logic hwrite,
    output var logic [2:0] hsize,
    output var logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // one single word transfer; released lines show inverted values
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        haddr <= ~a;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the touch preprocessor register bank
// assumes the host model drives the bus, this module the status link
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, swReset, convStop, funcStart, funcDone;
    logic drvXPos, drvXNeg, drvYPos, drvYNeg, penTouch, filterBusy, dataStore, dataRead;
    logic sharedTouchDataPin, convBusy, preprocBypass, irq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize, dataStoreType, dataReadType;
    logic [3:0] funcCode, filterApply;
    int bad_count = 0;
    int comparisons = 0;
    tpcds_core i_dut (.hready(hreadyout), .*);
    tpcds_host i_host (.hready(hreadyout), .*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic store(input logic [2:0] t);
        dataStore <= 1'b1;
        dataStoreType <= t;
        tk(1);
        dataStore <= 1'b0;
        tk(1);
    endtask
    task automatic t_cfg();
        rd(32'h38, 32'h0);
        rd(32'h3c, 32'h0);
        wr(32'h38, 32'h3c1e);
        rd(32'h38, 32'h3c1e);
        chk(hresp, 1'b0);
        chk(filterApply, 4'hf);
        chk(preprocBypass, 1'b0);
        wr(32'h38, 32'h2c14);
        rd(32'h38, 32'h2c14);
        wr(32'h3c, 32'hffff);
        rd(32'h3c, 32'h0);
        rd(32'h80, 32'h0);
        $display("end cfg");
    endtask
    task automatic t_func();
        logic [3:0] d [4] = '{4'b1100, 4'b0011, 4'b0110, 4'b1111};
        logic [15:0] e [4] = '{16'h2000, 16'h4000, 16'h8000, 16'he000};
        for (int i = 0; i < 10; i++) begin
            {drvXPos, drvXNeg, drvYPos, drvYNeg} <= d[i % 4];
            funcStart <= 1'b1;
            funcCode <= (i == 9) ? 4'hf : i[3:0];
            tk(1);
            funcStart <= 1'b0;
            rd(32'h3c, {16'h0, e[i % 4] | ((i == 9) ? 16'h0 : 16'h1 << i)});
            {drvXPos, drvXNeg, drvYPos, drvYNeg} <= 4'h0;
            convStop <= i[0];
            funcDone <= !i[0];
            tk(1);
            convStop <= 1'b0;
            funcDone <= 1'b0;
            rd(32'h3c, 32'h0);
        end
        $display("end func");
    endtask
    task automatic t_pin();
        logic [15:0] c [3] = '{16'h0000, 16'h8000, 16'h4000};
        store(3'h2);
        rd(32'h40, 32'h4);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                wr(32'h38, {16'h0, c[k]});
                tk(2);
                chk(sharedTouchDataPin, k == 1 ? p == 0 : k == 2 && p == 1);
            end
            dataRead <= 1'b1;
            dataReadType <= 3'h2;
            penTouch <= 1'b1;
            tk(1);
            dataRead <= 1'b0;
        end
        rd(32'h40, 32'h40);
        penTouch <= 1'b0;
        $display("end pin");
    endtask
    task automatic t_irq();
        wr(32'h44, 32'h7);
        wr(32'h48, 32'h1);
        store(3'h3);
        chk(irq, 1'b1);
        wr(32'h48, 32'h0);
        tk(2);
        chk(irq, 1'b0);
        wr(32'h48, 32'h1);
        tk(2);
        chk(irq, 1'b1);
        rd(32'h44, 32'h1);
        wr(32'h44, 32'h1);
        tk(2);
        chk(irq, 1'b0);
        $display("end irq");
    endtask
    task automatic t_filter();
        wr(32'h38, 32'h0402);
        filterBusy <= 1'b1;
        store(3'h1);
        chk(convBusy, 1'b1);
        rd(32'h40, 32'h28);
        filterBusy <= 1'b0;
        tk(2);
        rd(32'h40, 32'h0a);
        {drvXPos, drvXNeg, funcStart, funcCode} <= 7'h73;
        tk(1);
        funcStart <= 1'b0;
        {drvXPos, drvXNeg, swReset} <= 3'h1;
        tk(1);
        swReset <= 1'b0;
        rd(32'h38, 32'h0);
        rd(32'h3c, 32'h0);
        $display("end filter");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {swReset, convStop, funcStart, funcDone, penTouch, filterBusy} = 6'h0;
        {dataStore, dataRead, drvXPos, drvXNeg, drvYPos, drvYNeg} = 6'h0;
        {funcCode, dataStoreType, dataReadType} = 10'h0;
        rst = 1'b1;
        tk(12);
        rst <= 1'b0;
        tk(1);
        t_cfg();
        t_func();
        t_pin();
        t_irq();
        t_filter();
        final_report();
    end
    initial begin
        #100us;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
